// ---- design/adcc_top.sv ----
// Purpose: Control of a 10-bit successive-approximation converter
// Assumes: AXI4-Lite register access; comparator output from analog core
// Notes: Result pair has no reset and holds its value across resets
`timescale 1ns/10ps
`default_nettype none
module adcc_top (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Power state and RC oscillator pin
   input wire logic sleep_active,
   input wire logic rc_osc_pin,
   // Analog core
   input wire logic comparator_high,
   output logic [3:0] channel_select,
   output logic sample_connect,
   output logic [adcc_pkg::RES_W-1:0] dac_code,
   output logic neg_ref_select,
   output logic pos_ref_select,
   output logic [adcc_pkg::NUM_CH-1:0] digital_pin_mask,
   output logic calibrate_req
);
   import adcc_pkg::*;

   logic [7:0] ctrl0_reg; // Control register 0
   logic [7:0] portref_reg; // Port and reference config
   logic [7:0] fmt_reg; // Format, timing and clock
   logic [7:0] res_hi_reg; // Result high byte
   logic [7:0] res_lo_reg; // Result low byte
   logic [1:0] flag_reg; // Done flag and enable
   adcc_state_t state_reg; // Sequencer state
   logic [4:0] cnt_reg; // Period counter
   logic [3:0] bit_reg; // Current trial bit
   logic [RES_W-1:0] sar_reg; // Approximation register
   logic cmp_s1_reg; // Comparator sync stage 1
   logic cmp_s2_reg; // Comparator sync stage 2
   logic aw_hold_reg; // Write address captured
   logic [7:0] aw_addr_reg; // Captured write address
   logic w_hold_reg; // Write data captured
   logic [7:0] w_data_reg; // Captured write byte
   logic w_strb_reg; // Captured low-lane strobe
   logic wr_go; // Write commits now
   logic wr_ok; // Write address mapped
   logic [7:0] rd_mux; // Read data select
   logic rd_ok; // Read address mapped
   logic tad_tick; // One conversion clock period
   logic run; // Sequencer needs ticks
   logic [4:0] acq_tads; // Programmed acquisition length
   logic go_set; // Software starts conversion
   logic go_clr; // Software aborts conversion
   logic conv_done; // Last bit decided
   logic [RES_W-1:0] final_res; // Completed result
   logic [7:0] ctrl0_wdata; // Masked control 0 write

   ////////////////////////////////////////////////////////////////////////
   // Comparator synchroniser
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cmp_s1_reg <= 1'b0;
         cmp_s2_reg <= 1'b0;
      end else begin
         cmp_s1_reg <= comparator_high;
         cmp_s2_reg <= cmp_s1_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // AXI write channels, taken in either order
   assign s_axi_awready = !aw_hold_reg && !s_axi_bvalid;
   assign s_axi_wready = !w_hold_reg && !s_axi_bvalid;
   assign wr_go = aw_hold_reg && w_hold_reg;

   // Address capture
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_hold_reg <= 1'b1;
         aw_addr_reg <= s_axi_awaddr;
      end else if (wr_go) begin
         aw_hold_reg <= 1'b0;
      end
   end

   // Data capture, low byte lane only
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_hold_reg <= 1'b0;
         w_data_reg <= 8'h00;
         w_strb_reg <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_hold_reg <= 1'b1;
         w_data_reg <= s_axi_wdata[7:0];
         w_strb_reg <= s_axi_wstrb[0];
      end else if (wr_go) begin
         w_hold_reg <= 1'b0;
      end
   end

   // Write address decode
   always_comb begin
      unique case (aw_addr_reg)
         ADDR_CTRL0, ADDR_PORTREF, ADDR_FMT: wr_ok = 1'b1;
         ADDR_RES_HI, ADDR_RES_LO, ADDR_FLAG: wr_ok = 1'b1;
         default: wr_ok = 1'b0;
      endcase
   end

   // Write response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register write strobes
   assign ctrl0_wdata = w_data_reg & CTRL0_MASK;
   assign go_set = wr_go && w_strb_reg && aw_addr_reg == ADDR_CTRL0 &&
      ctrl0_wdata[CTRL0_GO] && ctrl0_wdata[CTRL0_EN] &&
      ctrl0_reg[CTRL0_EN] && state_reg == ST_SAMPLE;
   assign go_clr = wr_go && w_strb_reg && aw_addr_reg == ADDR_CTRL0 &&
      (!ctrl0_wdata[CTRL0_GO] || !ctrl0_wdata[CTRL0_EN]);

   // Control register 0; busy bit owned by sequencer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl0_reg <= REG_RESET;
      end else begin
         if (wr_go && w_strb_reg && aw_addr_reg == ADDR_CTRL0) begin
            ctrl0_reg[7:2] <= ctrl0_wdata[7:2];
            ctrl0_reg[CTRL0_EN] <= ctrl0_wdata[CTRL0_EN];
         end
         if (go_set) begin
            ctrl0_reg[CTRL0_GO] <= 1'b1;
         end else if (conv_done || go_clr) begin
            ctrl0_reg[CTRL0_GO] <= 1'b0;
         end
      end
   end

   // Port reference and format registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         portref_reg <= REG_RESET;
         fmt_reg <= REG_RESET;
      end else if (wr_go && w_strb_reg) begin
         if (aw_addr_reg == ADDR_PORTREF) begin
            portref_reg <= w_data_reg & PR_MASK;
         end
         if (aw_addr_reg == ADDR_FMT) begin
            fmt_reg <= w_data_reg & FMT_MASK;
         end
      end
   end

   // Done flag: set wins over software clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flag_reg <= 2'b00;
      end else begin
         if (wr_go && w_strb_reg && aw_addr_reg == ADDR_FLAG) begin
            flag_reg <= w_data_reg[1:0];
         end
         if (conv_done) begin
            flag_reg[FLAG_DONE] <= 1'b1;
         end
      end
   end

   // Completed result with last trial bit from comparator
   always_comb begin
      final_res = sar_reg;
      final_res[bit_reg] = cmp_s2_reg;
   end

   // Result pair: no reset, keeps value over aborts
   always_ff @(posedge aclk) begin
      if (conv_done) begin
         if (fmt_reg[FMT_JUST]) begin
            res_hi_reg <= {6'h00, final_res[9:8]};
            res_lo_reg <= final_res[7:0];
         end else begin
            res_hi_reg <= final_res[9:2];
            res_lo_reg <= {final_res[1:0], 6'h00};
         end
      end else if (wr_go && w_strb_reg && aw_addr_reg == ADDR_RES_HI) begin
         res_hi_reg <= w_data_reg;
      end else if (wr_go && w_strb_reg && aw_addr_reg == ADDR_RES_LO) begin
         res_lo_reg <= w_data_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read channel
   assign s_axi_arready = !s_axi_rvalid;

   // Read address decode and data select
   always_comb begin
      rd_ok = 1'b1;
      unique case (s_axi_araddr)
         ADDR_CTRL0: rd_mux = ctrl0_reg;
         ADDR_PORTREF: rd_mux = portref_reg;
         ADDR_FMT: rd_mux = fmt_reg;
         ADDR_RES_HI: rd_mux = res_hi_reg;
         ADDR_RES_LO: rd_mux = res_lo_reg;
         ADDR_FLAG: rd_mux = {6'h00, flag_reg};
         default: begin
            rd_mux = 8'h00;
            rd_ok = 1'b0;
         end
      endcase
   end

   // Read data register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {24'h00_0000, rd_mux};
         s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Acquisition length by code
   always_comb begin
      unique case (fmt_reg[FMT_ACQ_LSB +: 3])
         3'b000: acq_tads = 5'd0;
         3'b001: acq_tads = 5'd2;
         3'b010: acq_tads = 5'd4;
         3'b011: acq_tads = 5'd6;
         3'b100: acq_tads = 5'd8;
         3'b101: acq_tads = 5'd12;
         3'b110: acq_tads = 5'd16;
         default: acq_tads = 5'd20;
      endcase
   end

   // Tick source runs whenever the sequencer is active
   assign run = (state_reg != ST_SAMPLE);

   adcc_tad_gen u_tad (
      .aclk(aclk),
      .aresetn(aresetn),
      .run(run),
      .clk_sel(fmt_reg[2:0]),
      .sleep_active(sleep_active),
      .rc_osc_pin(rc_osc_pin),
      .tad_tick(tad_tick)
   );

   // Last bit decided on a conversion tick
   assign conv_done = state_reg == ST_CONV && tad_tick && !go_clr &&
      cnt_reg != 5'd0 && bit_reg == 4'd0;

   ////////////////////////////////////////////////////////////////////////
   // Acquisition and conversion sequencer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= ST_SAMPLE;
         cnt_reg <= 5'd0;
         bit_reg <= 4'd0;
         sar_reg <= '0;
      end else begin
         unique case (state_reg)
            ST_SAMPLE: begin
               cnt_reg <= 5'd0;
               if (go_set && acq_tads == 5'd0) begin
                  state_reg <= ST_CONV;
               end else if (go_set) begin
                  state_reg <= ST_ACQ;
               end
            end
            ST_ACQ: begin
               if (go_clr) begin
                  state_reg <= ST_WAIT;
                  cnt_reg <= 5'd0;
               end else if (tad_tick && cnt_reg == acq_tads - 5'd1) begin
                  state_reg <= ST_CONV;
                  cnt_reg <= 5'd0;
               end else if (tad_tick) begin
                  cnt_reg <= cnt_reg + 5'd1;
               end
            end
            ST_CONV: begin
               if (go_clr) begin
                  state_reg <= ST_WAIT;
                  cnt_reg <= 5'd0;
               end else if (tad_tick && cnt_reg == 5'd0) begin
                  cnt_reg <= 5'd1; // First period: hold settles
                  bit_reg <= 4'(RES_W - 1);
                  sar_reg <= '0;
               end else if (tad_tick && bit_reg == 4'd0) begin
                  state_reg <= ST_WAIT; // Eleventh period done
                  sar_reg <= final_res;
                  cnt_reg <= 5'd0;
               end else if (tad_tick) begin
                  sar_reg[bit_reg] <= cmp_s2_reg;
                  bit_reg <= bit_reg - 4'd1;
                  cnt_reg <= cnt_reg + 5'd1;
               end
            end
            ST_WAIT: begin
               if (tad_tick && cnt_reg == WAIT_TADS - 5'd1) begin
                  state_reg <= ST_SAMPLE;
                  cnt_reg <= 5'd0;
               end else if (tad_tick) begin
                  cnt_reg <= cnt_reg + 5'd1;
               end
            end
         endcase
      end
   end

   // Trial code to the comparator DAC
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dac_code <= '0;
      end else if (state_reg == ST_CONV && cnt_reg != 5'd0) begin
         dac_code <= sar_reg | (RES_W'(1) << bit_reg);
      end else begin
         dac_code <= '0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Analog controls from registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sample_connect <= 1'b0;
         channel_select <= 4'h0;
         neg_ref_select <= 1'b0;
         pos_ref_select <= 1'b0;
         calibrate_req <= 1'b0;
      end else begin
         // Hold cap disconnected while converting
         sample_connect <= ctrl0_reg[CTRL0_EN] &&
            (state_reg == ST_SAMPLE || state_reg == ST_ACQ) &&
            !(go_set && acq_tads == 5'd0) &&
            !(state_reg == ST_ACQ && tad_tick &&
              cnt_reg == acq_tads - 5'd1);
         channel_select <= ctrl0_reg[CTRL0_CHS_LSB +: 4];
         neg_ref_select <= portref_reg[PR_NEG];
         pos_ref_select <= portref_reg[PR_POS];
         calibrate_req <= ctrl0_reg[CTRL0_CAL];
      end
   end

   // Pin role decode, one generate per channel
   genvar ch;
   generate
      for (ch = 0; ch < NUM_CH; ch++) begin : g_role
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               digital_pin_mask[ch] <= 1'b0;
            end else begin
               // Channel digital once code passes its threshold
               digital_pin_mask[ch] <=
                  ({1'b0, portref_reg[3:0]} >= 5'(15 - ch));
            end
         end
      end
   endgenerate
endmodule // adcc_top
`default_nettype wire

// ---- design/adcc_pkg.sv ----
// Purpose: Constants, field layouts and state codes of the converter control
// Assumes: 8-bit registers, each in the low byte of one aligned 32-bit word
// Notes: Notes on behaviour list below
//
// Notes on behaviour
// - Bit 5 picks external or ground negative reference
// - Bit 4 picks external or supply positive reference
// - Pin role code turns channels digital downward
// - Justify bit one right, zero left
// - Acquisition code maps to 0..20 clock periods
// - Clock code picks divider or internal RC
// - RC clock starts one instruction cycle late
// - Done loads result, clears busy, sets flag
// - Reset clears registers, disables, aborts conversion
// - Result pair untouched by reset
// - Sleep conversions only on internal RC clock
// - Zero acquisition code converts immediately on start
// - Nonzero code samples programmed periods then converts
// - Sampling resumes after every completed conversion
// - Busy bit set through acquisition and conversion
// - Two clock periods wait before next acquisition
// - Unimplemented bits read as zero
// - Holding capacitor disconnected at conversion start
// - Eleven clock periods per conversion
// - Software abort keeps previous result pair
// - Four-bit channel select, codes above 11 unused
// - Busy bit reflects conversion, separate enable bit
package adcc_pkg;
   // Register byte addresses
   localparam logic [7:0] ADDR_CTRL0 = 8'h00;
   localparam logic [7:0] ADDR_PORTREF = 8'h04;
   localparam logic [7:0] ADDR_FMT = 8'h08;
   localparam logic [7:0] ADDR_RES_HI = 8'h0C;
   localparam logic [7:0] ADDR_RES_LO = 8'h10;
   localparam logic [7:0] ADDR_FLAG = 8'h14;
   // Control register 0 fields
   localparam int CTRL0_CAL = 7;
   localparam int CTRL0_CHS_LSB = 2;
   localparam int CTRL0_GO = 1;
   localparam int CTRL0_EN = 0;
   localparam logic [7:0] CTRL0_MASK = 8'hBF;
   // Port reference fields
   localparam int PR_NEG = 5;
   localparam int PR_POS = 4;
   localparam logic [7:0] PR_MASK = 8'h3F;
   // Format register fields
   localparam int FMT_JUST = 7;
   localparam int FMT_ACQ_LSB = 3;
   localparam logic [7:0] FMT_MASK = 8'hBF;
   // Flag register: done flag and its enable
   localparam int FLAG_DONE = 0;
   localparam int FLAG_IE = 1;
   // Reset values of control registers
   localparam logic [7:0] REG_RESET = 8'h00;
   // Timing counts in conversion clock periods
   localparam logic [4:0] CONV_TADS = 5'd11;
   localparam logic [4:0] WAIT_TADS = 5'd2;
   // Oscillator periods in one instruction cycle
   localparam logic [2:0] INSTR_CYC_OSC = 3'd4;
   // Number of channels and result width
   localparam int NUM_CH = 12;
   localparam int RES_W = 10;
   // Clock select codes using the internal RC
   localparam logic [1:0] CLK_RC_LOW = 2'b11;
   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   // Sequencer states
   typedef enum logic [3:0] {
      ST_SAMPLE = 4'b0001,
      ST_ACQ = 4'b0010,
      ST_CONV = 4'b0100,
      ST_WAIT = 4'b1000
   } adcc_state_t;
endpackage

// ---- design/adcc_tad_gen.sv ----
// Purpose: Conversion clock period tick generator
// Assumes: Oscillator is aclk; RC oscillator arrives as an async pin
// Notes: Emits one-cycle tick per conversion clock period while run is high
`timescale 1ns/10ps
`default_nettype none
module adcc_tad_gen (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Control
   input wire logic run,
   input wire logic [2:0] clk_sel,
   input wire logic sleep_active,
   input wire logic rc_osc_pin,
   // Tick out
   output logic tad_tick
);
   import adcc_pkg::*;

   logic rc_s1_reg; // First synchroniser stage
   logic rc_s2_reg; // Second synchroniser stage
   logic rc_s3_reg; // Edge history
   logic [5:0] div_reg; // Oscillator divider
   logic [2:0] dly_reg; // RC start delay count
   logic rc_sel; // Internal RC chosen
   logic [5:0] div_last; // Terminal divider count

   ////////////////////////////////////////////////////////////////////////
   // RC pin synchroniser and edge history
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rc_s1_reg <= 1'b0;
         rc_s2_reg <= 1'b0;
         rc_s3_reg <= 1'b0;
      end else begin
         rc_s1_reg <= rc_osc_pin;
         rc_s2_reg <= rc_s1_reg;
         rc_s3_reg <= rc_s2_reg;
      end
   end

   // Divider terminal count by code
   always_comb begin
      rc_sel = (clk_sel[1:0] == CLK_RC_LOW);
      unique case (clk_sel)
         3'b000: div_last = 6'd1; // Divide by 2
         3'b001: div_last = 6'd7; // Divide by 8
         3'b010: div_last = 6'd31; // Divide by 32
         3'b100: div_last = 6'd3; // Divide by 4
         3'b101: div_last = 6'd15; // Divide by 16
         3'b110: div_last = 6'd63; // Divide by 64
         default: div_last = 6'd0; // RC codes, divider unused
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Oscillator divider, restarts with each run
   always_ff @(posedge aclk) begin
      if (!aresetn || !run || div_reg == div_last) begin
         div_reg <= 6'd0;
      end else begin
         div_reg <= div_reg + 6'd1;
      end
   end

   // RC start delay of one instruction cycle
   always_ff @(posedge aclk) begin
      if (!aresetn || !run) begin
         dly_reg <= 3'd0;
      end else if (rc_sel && dly_reg != INSTR_CYC_OSC) begin
         dly_reg <= dly_reg + 3'd1;
      end
   end

   // Tick select; divided clock stalls in sleep
   always_comb begin
      if (!run) begin
         tad_tick = 1'b0;
      end else if (rc_sel) begin
         tad_tick = (dly_reg == INSTR_CYC_OSC) && rc_s2_reg && !rc_s3_reg;
      end else begin
         tad_tick = !sleep_active && (div_reg == div_last);
      end
   end
endmodule // adcc_tad_gen
`default_nettype wire

// ---- testbench/adcc_analog_model.sv ----
// Purpose: Analog input with sample-and-hold and comparator
// Assumes: Ideal comparator, one clock to settle
// Notes: Held charge freezes while disconnected
`timescale 1ns/10ps
`default_nettype none
module adcc_analog_model (
   // Clock
   input wire logic aclk,
   // Converter side
   input wire logic sample_connect,
   input wire logic [adcc_pkg::RES_W-1:0] dac_code,
   output logic comparator_high,
   // Input level
   input wire logic [adcc_pkg::RES_W-1:0] level
);
   import adcc_pkg::*;
   logic [RES_W-1:0] held; // Capacitor charge
   // Track while connected, compare held charge
   always_ff @(posedge aclk) begin
      if (sample_connect)
         held <= level;
      comparator_high <= held >= dac_code;
   end
endmodule // adcc_analog_model
`default_nettype wire

// ---- testbench/adcc_assertions.sv ----
// Purpose: Port assertions of the converter control
// Assumes: Sees the top ports only
// Notes: Bound to adcc_top at the foot
`timescale 1ns/10ps
`default_nettype none
module adcc_checker (
   // Clock, reset and bus
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_wvalid,
   // Analog side
   input wire logic sample_connect,
   input wire logic [adcc_pkg::RES_W-1:0] dac_code,
   input wire logic neg_ref_select,
   input wire logic pos_ref_select,
   input wire logic [adcc_pkg::NUM_CH-1:0] digital_pin_mask
);
   import adcc_pkg::*;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // Control register read taken
   sequence s_rd_ctrl;
      s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_CTRL0;
   endsequence
   // Wait out, then sample again
   sequence s_resume;
      !sample_connect [*3] ##[1:1000] sample_connect;
   endsequence
   a_pin_thermo: assert property (
      ((~digital_pin_mask) & (~digital_pin_mask + 12'h001)) == 12'h000)
      else $error("pin mask broken");
   a_hold_no_trial: assert property (
      sample_connect |-> dac_code == 10'h000)
      else $error("trial while sampling");
   a_ref_by_write: assert property (
      $changed({neg_ref_select, pos_ref_select})
      |-> $past(s_axi_wvalid, 2) || $past(s_axi_wvalid, 3))
      else $error("reference moved alone");
   a_midscale_first: assert property (
      $past(dac_code) == 10'h000 && dac_code != 10'h000
      |-> dac_code == 10'h200)
      else $error("first trial wrong");
   a_trial_halves: assert property (
      $past(dac_code) != 10'h000 && dac_code != 10'h000 && $changed(dac_code)
      |-> (dac_code & -dac_code) == (($past(dac_code) & -$past(dac_code)) >> 1))
      else $error("trial step wrong");
   a_busy_in_conv: assert property (
      s_rd_ctrl ##1 dac_code != 10'h000 |-> s_axi_rdata[1])
      else $error("busy low in conversion");
   a_unused_zero: assert property (
      s_axi_arvalid && s_axi_arready && s_axi_araddr <= ADDR_FMT
      |=> s_axi_rdata[31:8] == 24'h000000 && !s_axi_rdata[6])
      else $error("unused bits set");
   a_resume_after: assert property (
      $past(dac_code) != 10'h000 && dac_code == 10'h000 |-> s_resume)
      else $error("sampling not resumed");
endmodule // adcc_checker
bind adcc_top adcc_checker i_adcc_checker (.aclk(aclk), .aresetn(aresetn),
   .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_wvalid(s_axi_wvalid), .sample_connect(sample_connect),
   .dac_code(dac_code), .neg_ref_select(neg_ref_select),
   .pos_ref_select(pos_ref_select), .digital_pin_mask(digital_pin_mask));
`default_nettype wire

// ---- testbench/adc_acquire_convert_control_tb.sv ----
// Purpose: Self-checking bench of the converter control
// Assumes: Divided clocks; RC pin held low
// Notes: Result pair followed through abort and reset
`timescale 1ns/10ps
`default_nettype none
module adc_acquire_convert_control_tb;
   import adcc_pkg::*;
   logic aclk, aresetn, awv, wv, bv, brd, arv, rv, rrd, awr, wrd, arr;
   logic smp, nref, pref, cmp, cal, slp;
   logic [1:0] bresp, rresp, resp;
   logic [3:0] chan;
   logic [7:0] awa, ara;
   logic [9:0] dac, level;
   logic [11:0] dmask;
   logic [31:0] wd, rdat;
   int err_count, tests_run;
   adcc_top i_adcc_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
      .s_axi_wstrb(4'h1), .s_axi_wvalid(wv), .s_axi_wready(wrd),
      .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(brd),
      .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
      .s_axi_rready(rrd), .sleep_active(slp), .rc_osc_pin(1'b0),
      .comparator_high(cmp), .channel_select(chan), .sample_connect(smp),
      .dac_code(dac), .neg_ref_select(nref), .pos_ref_select(pref),
      .digital_pin_mask(dmask), .calibrate_req(cal));
   adcc_analog_model i_adcc_analog_model (.aclk(aclk), .sample_connect(smp),
      .dac_code(dac), .comparator_high(cmp), .level(level));
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   task automatic chk(input string s, input logic [31:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", s, exp, seen);
      end
   endtask
   // Write: address and data offered together
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      awa <= a;
      wd <= {24'h000000, d};
      {awv, wv, brd} <= 3'h7;
      do begin
         @(posedge aclk);
         if (awr) awv <= 1'b0;
         if (wrd) wv <= 1'b0;
      end while (!bv);
      brd <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      ara <= a;
      {arv, rrd} <= 2'h3;
      do begin
         @(posedge aclk);
         if (arr) arv <= 1'b0;
      end while (!rv);
      d = rdat;
      resp = rresp;
      rrd <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e, string s);
      logic [31:0] d;
      rd(a, d);
      chk(s, d, e);
   endtask
   task automatic t_reset();
      rc(ADDR_CTRL0, 32'h0, "ctrl0");
      rc(ADDR_FMT, 32'h0, "fmt");
      rc(8'h18, 32'h0, "unmapped");
      chk("resp", {30'h0, resp}, {30'h0, RESP_SLVERR});
   endtask
   task automatic t_ports();
      logic [11:0] e;
      for (int k = 0; k < 16; k++) begin
         for (int ch = 0; ch < 12; ch++)
            e[ch] = k >= 15 - ch;
         wr(ADDR_PORTREF, {2'h3, k[1:0], k[3:0]});
         repeat (2) @(posedge aclk);
         chk("mask", {20'h0, dmask}, {20'h0, e});
         chk("refs", {30'h0, nref, pref}, {30'h0, k[1:0]});
         rc(ADDR_PORTREF, {26'h0, k[1:0], k[3:0]}, "portref");
      end
   endtask
   // Configure, enable, start, poll, read result
   task automatic t_conv(input logic [7:0] f, input logic [9:0] lv);
      logic [31:0] d;
      wr(ADDR_FLAG, 8'h00);
      wr(ADDR_FMT, f);
      level <= lv;
      wr(ADDR_CTRL0, 8'h15);
      repeat (30) @(posedge aclk);
      wr(ADDR_CTRL0, 8'h17);
      rd(ADDR_CTRL0, d);
      chk("busy", {31'h0, d[1]}, 32'h1);
      chk("smp", {31'h0, smp}, {31'h0, f[5:3] != 3'h0});
      while (smp) @(posedge aclk);
      level <= ~lv;
      chk("chan", {28'h0, chan}, 32'h5);
      while (d[1]) rd(ADDR_CTRL0, d);
      if (f[7]) begin
         rc(ADDR_RES_HI, {30'h0, lv[9:8]}, "hi");
         rc(ADDR_RES_LO, {24'h0, lv[7:0]}, "lo");
      end else begin
         rc(ADDR_RES_HI, {24'h0, lv[9:2]}, "hi");
         rc(ADDR_RES_LO, {24'h0, lv[1:0], 6'h0}, "lo");
      end
      rc(ADDR_FLAG, 32'h1, "flag");
      repeat (40) @(posedge aclk);
      chk("resample", {31'h0, smp}, 32'h1);
   endtask
   task automatic t_abort();
      wr(ADDR_FMT, 8'h06);
      level <= 10'h3FF;
      wr(ADDR_CTRL0, 8'h17);
      repeat (100) @(posedge aclk);
      wr(ADDR_CTRL0, 8'h15);
      rc(ADDR_CTRL0, 32'h15, "abort");
      rc(ADDR_RES_LO, 32'h80, "kept");
      repeat (200) @(posedge aclk);
   endtask
   task automatic t_rst_mid();
      wr(ADDR_CTRL0, 8'h97);
      slp <= 1'b1;
      repeat (800) @(posedge aclk);
      chk("cal", {31'h0, cal}, 32'h1);
      rc(ADDR_CTRL0, 32'h97, "stall");
      {aresetn, slp} <= 2'h0;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      chk("off", {30'h0, cal, smp}, 32'h0);
      rc(ADDR_CTRL0, 32'h0, "ctrl0");
      rc(ADDR_RES_LO, 32'h80, "res");
   endtask
   task automatic end_of_test();
      $display("checks %0d errors %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      {aresetn, awv, wv, brd, arv, rrd, slp} = 7'h00;
      {awa, ara, wd, level} = 58'h0;
      err_count = 0;
      tests_run = 0;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_reset();
      t_ports();
      t_conv(8'h81, 10'h2A5);
      t_conv(8'h11, 10'h15A);
      t_abort();
      t_rst_mid();
      end_of_test();
   end
   initial begin
      repeat (20000) @(posedge aclk);
      err_count++;
      end_of_test();
   end
endmodule // adc_acquire_convert_control_tb
`default_nettype wire
